// File: rtl/brm_pkg.sv
// Package for the banked register map: descriptor table, offsets, masks,
// reset values and carrier types shared by the map and its neighbours.
// Assumes one byte register per offset and a single-bit bank selector.
package brm_pkg;

   // Geometry of the register space
   localparam int          BANK_COUNT   = 2;
   localparam int          BANK_SIZE    = 256;
   localparam int          SPACE_BYTES  = BANK_COUNT * BANK_SIZE;
   localparam int          INDEX_W      = 9;
   localparam int          REG_COUNT    = 48;

   // Own control register beyond the banked space (word index)
   localparam logic [8:0]  FLAG_INDEX   = 9'h100;
   localparam int          FLAG_BANK_BIT = 0;

   // Reset values
   localparam logic [7:0]  REG_RESET    = 8'h00;
   localparam logic [31:0] RDATA_RESET  = 32'h00000000;

   // Per-bit access masks by access class
   localparam logic [7:0]  RM_RW = 8'hFF;
   localparam logic [7:0]  WM_RW = 8'hFF;
   localparam logic [7:0]  RM_WO = 8'h00;
   localparam logic [7:0]  WM_WO = 8'hFF;
   localparam logic [7:0]  RM_MX = 8'hFF;
   localparam logic [7:0]  WM_MX = 8'h0F;

   // Offsets of registers with side effects, bank 0 only
   localparam logic [7:0]  OFS_DEC_HIGH = 8'hE4;
   localparam logic [7:0]  OFS_DEC_LOW  = 8'hE5;
   localparam logic [7:0]  OFS_MUL_X    = 8'hE8;
   localparam logic [7:0]  OFS_MUL_Y    = 8'hE9;
   localparam logic [7:0]  OFS_MUL_HIGH = 8'hEA;
   localparam logic [7:0]  OFS_MUL_LOW  = 8'hEB;

   // AHB transfer type bit that marks an active transfer
   localparam int          HTRANS_ACTIVE_BIT = 1;

   typedef struct packed {
      logic [7:0] offset;
      logic [7:0] rmask;
      logic [7:0] wmask;
      logic       both_banks;   // Same flops seen in bank 0 and bank 1
   } brm_reg_desc_type;

   // Result word handed over by the decimator
   typedef struct packed {
      logic        load;
      logic [15:0] value;
   } brm_dec_in_type;

   typedef enum logic [1:0] {
      BRM_PH_IDLE,
      BRM_PH_WRITE,
      BRM_PH_READ
   } brm_phase_type;

   // Plain storage registers, table order is the reg_values order
   localparam brm_reg_desc_type REG_TABLE [REG_COUNT] = '{
      '{8'h00, RM_RW, WM_RW, 1'b0}, '{8'h01, RM_RW, WM_RW, 1'b0},
      '{8'h02, RM_RW, WM_RW, 1'b0}, '{8'h03, RM_RW, WM_RW, 1'b0},
      '{8'h04, RM_RW, WM_RW, 1'b0}, '{8'h05, RM_RW, WM_RW, 1'b0},
      '{8'h06, RM_RW, WM_RW, 1'b0}, '{8'h07, RM_RW, WM_RW, 1'b0},
      '{8'h08, RM_RW, WM_RW, 1'b0}, '{8'h09, RM_RW, WM_RW, 1'b0},
      '{8'h0A, RM_RW, WM_RW, 1'b0}, '{8'h0B, RM_RW, WM_RW, 1'b0},
      '{8'h20, RM_MX, WM_MX, 1'b0}, '{8'h21, RM_WO, WM_WO, 1'b0},
      '{8'h22, RM_RW, WM_RW, 1'b0}, '{8'h23, RM_MX, WM_MX, 1'b0},
      '{8'h24, RM_MX, WM_MX, 1'b0}, '{8'h25, RM_WO, WM_WO, 1'b0},
      '{8'h26, RM_RW, WM_RW, 1'b0}, '{8'h27, RM_MX, WM_MX, 1'b0},
      '{8'h28, RM_MX, WM_MX, 1'b0}, '{8'h29, RM_WO, WM_WO, 1'b0},
      '{8'h60, RM_RW, WM_RW, 1'b0}, '{8'h63, RM_RW, WM_RW, 1'b0},
      '{8'h64, RM_MX, WM_MX, 1'b0}, '{8'h65, RM_MX, WM_MX, 1'b0},
      '{8'h66, RM_RW, WM_RW, 1'b0},
      '{8'h80, RM_RW, WM_RW, 1'b1}, '{8'h81, RM_RW, WM_RW, 1'b1},
      '{8'h82, RM_RW, WM_RW, 1'b1}, '{8'h83, RM_RW, WM_RW, 1'b1},
      '{8'h84, RM_RW, WM_RW, 1'b1}, '{8'h85, RM_RW, WM_RW, 1'b1},
      '{8'h86, RM_RW, WM_RW, 1'b1}, '{8'h87, RM_RW, WM_RW, 1'b1},
      '{8'h90, RM_RW, WM_RW, 1'b1}, '{8'h91, RM_RW, WM_RW, 1'b1},
      '{8'h92, RM_RW, WM_RW, 1'b1}, '{8'h93, RM_RW, WM_RW, 1'b1},
      '{8'h94, RM_RW, WM_RW, 1'b1}, '{8'h95, RM_RW, WM_RW, 1'b1},
      '{8'h96, RM_RW, WM_RW, 1'b1}, '{8'h97, RM_RW, WM_RW, 1'b1},
      '{8'hDA, RM_RW, WM_RW, 1'b0}, '{8'hDB, RM_RW, WM_RW, 1'b0},
      '{8'hDD, RM_RW, WM_RW, 1'b0}, '{8'hDE, RM_RW, WM_RW, 1'b0},
      '{8'hE0, RM_RW, WM_RW, 1'b0}
   };

endpackage : brm_pkg

// File: rtl/brm_register_map.sv
// Banked byte register map reached over an AHB-Lite slave port.
// Assumes a single master, word-wide single transfers, and that the
// decimator result arrives from logic on hclk.
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps

module brm_register_map
   import brm_pkg::*;
#(
   parameter int HDATA_WIDTH = 32
) (
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      hsel,
   input  wire logic [31:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic [HDATA_WIDTH-1:0]    hwdata,
   input  wire logic                      hready,
   output logic                           hreadyout,
   output logic                           hresp,
   output logic [HDATA_WIDTH-1:0]         hrdata,
   input  wire brm_pkg::brm_dec_in_type   dec_in,
   output logic [brm_pkg::REG_COUNT-1:0][7:0] reg_values,
   output logic                           bank_select_flag,
   output logic                           reserved_hit
);
   import brm_pkg::*;

   // Only the word-wide bus is served
   if (HDATA_WIDTH != 32) begin : g_width_check
      $error("brm_register_map: HDATA_WIDTH must be 32");
   end

   // The decoder splits the index into one flag-word bit and a byte offset,
   // so the package geometry has to agree with that split
   if (SPACE_BYTES != 512) begin : g_space_check
      $error("brm_register_map: register space must be 512 bytes");
   end
   if (BANK_SIZE != 256) begin : g_bank_check
      $error("brm_register_map: a bank must span an 8-bit offset");
   end
   if (INDEX_W != 9) begin : g_index_check
      $error("brm_register_map: index must be flag word bit plus offset");
   end
   if (FLAG_BANK_BIT > 7) begin : g_flag_bit_check
      $error("brm_register_map: flag bit must lie in the data byte");
   end

   brm_phase_type                 state_reg, state_next;
   logic [7:0]                    ph_ofs_reg;
   logic                          ph_bank_reg;
   logic                          ph_flag_reg;
   logic                          ph_rsvd_reg;
   logic [7:0]                    store_reg [REG_COUNT];
   logic [7:0]                    dec_high_reg, dec_low_reg;
   logic [7:0]                    mul_x_reg, mul_y_reg;
   logic [15:0]                   mul_prod_reg;
   logic                          flag_reg;
   logic                          reserved_reg;
   logic                          hreadyout_reg;
   logic [31:0]                   hrdata_reg;

   // Address phase decode
   wire        take      = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
   wire [8:0]  take_idx  = haddr[INDEX_W+1:2];
   wire        take_flag = (take_idx == FLAG_INDEX);
   wire        take_rsvd = take_idx[8] & ~take_flag;

   // Data phase commit points
   wire        wr_commit = (state_reg == BRM_PH_WRITE);
   wire        rd_commit = (state_reg == BRM_PH_READ);
   wire [7:0]  wdata     = hwdata[7:0];

   // Per-entry hit on the captured target
   logic [REG_COUNT-1:0] hit;
   genvar gi;
   for (gi = 0; gi < REG_COUNT; gi++) begin : g_entry
      // A reserved index above the flag word shares its low offset bits
      // with real registers, so it must be kept out of every hit
      assign hit[gi] = ~ph_flag_reg & ~ph_rsvd_reg
                     & (ph_ofs_reg == REG_TABLE[gi].offset)
                     & (~ph_bank_reg | REG_TABLE[gi].both_banks);

      // Storage seen from outside straight from its flops
      assign reg_values[gi] = store_reg[gi];

      // Written bits follow the write mask, the rest hold.
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            store_reg[gi] <= REG_RESET;
         end else if (wr_commit && hit[gi]) begin
            store_reg[gi] <= (store_reg[gi] & ~REG_TABLE[gi].wmask)
                           | (wdata & REG_TABLE[gi].wmask);
         end
      end
   end

   // Side-effect registers live in bank 0 only
   wire bank0     = ~ph_flag_reg & ~ph_bank_reg & ~ph_rsvd_reg;
   wire hit_dec_h = bank0 & (ph_ofs_reg == OFS_DEC_HIGH);
   wire hit_dec_l = bank0 & (ph_ofs_reg == OFS_DEC_LOW);
   wire hit_mul_x = bank0 & (ph_ofs_reg == OFS_MUL_X);
   wire hit_mul_y = bank0 & (ph_ofs_reg == OFS_MUL_Y);
   wire hit_mul_h = bank0 & (ph_ofs_reg == OFS_MUL_HIGH);
   wire hit_mul_l = bank0 & (ph_ofs_reg == OFS_MUL_LOW);
   wire hit_spec  = hit_dec_h | hit_dec_l | hit_mul_x | hit_mul_y
                  | hit_mul_h | hit_mul_l;
   wire any_hit   = (|hit) | hit_spec | ph_flag_reg;

   // Read data: every bit passes its own read mask
   logic [7:0] store_rd;
   always_comb begin
      store_rd = 8'h00;
      for (int i = 0; i < REG_COUNT; i++) begin
         if (hit[i]) begin
            store_rd = store_rd | (store_reg[i] & REG_TABLE[i].rmask);
         end
      end
   end

   wire [7:0] spec_rd = hit_dec_h ? dec_high_reg :
                        hit_dec_l ? dec_low_reg :
                        hit_mul_h ? mul_prod_reg[15:8] :
                        hit_mul_l ? mul_prod_reg[7:0] : 8'h00;
   wire [7:0] flag_rd = ph_flag_reg ?
                        8'(flag_reg) << FLAG_BANK_BIT : 8'h00;
   wire [7:0] rd_byte = ph_rsvd_reg ? 8'h00 : (store_rd | spec_rd | flag_rd);

   // Reads take one wait state so a write just before is already stored
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BRM_PH_READ: state_next = BRM_PH_IDLE;
         default: begin
            if (take) begin
               state_next = hwrite ? BRM_PH_WRITE : BRM_PH_READ;
            end else begin
               state_next = BRM_PH_IDLE;
            end
         end
      endcase
   end

   // Capture of the access target: bank from the flag, offset from haddr
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg   <= BRM_PH_IDLE;
         ph_ofs_reg  <= 8'h00;
         ph_bank_reg <= 1'b0;
         ph_flag_reg <= 1'b0;
         ph_rsvd_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (take) begin
            ph_ofs_reg  <= take_idx[7:0];
            ph_bank_reg <= flag_reg;
            ph_flag_reg <= take_flag;
            ph_rsvd_reg <= take_rsvd;
         end
      end
   end

   // Bus answer: zero-wait writes, one-wait reads, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_reg <= 1'b1;
         hrdata_reg    <= RDATA_RESET;
      end else begin
         if (take && !hwrite) begin
            hreadyout_reg <= 1'b0;
         end else if (rd_commit) begin
            hreadyout_reg <= 1'b1;
            hrdata_reg    <= {24'h000000, rd_byte};
         end
      end
   end

   // Bank-select flag, written through its own control word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_reg <= 1'b0;
      end else if (wr_commit && ph_flag_reg) begin
         flag_reg <= wdata[FLAG_BANK_BIT];
      end
   end

   // Decimator bytes: a new result wins over a clearing read.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dec_high_reg <= REG_RESET;
         dec_low_reg  <= REG_RESET;
      end else if (dec_in.load) begin
         dec_high_reg <= dec_in.value[15:8];
         dec_low_reg  <= dec_in.value[7:0];
      end else if (rd_commit) begin
         if (hit_dec_h) begin
            dec_high_reg <= REG_RESET;
         end
         if (hit_dec_l) begin
            dec_low_reg <= REG_RESET;
         end
      end
   end

   // Multiplier operands are write-only; the product is read-only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mul_x_reg    <= REG_RESET;
         mul_y_reg    <= REG_RESET;
         mul_prod_reg <= 16'h0000;
      end else begin
         if (wr_commit && hit_mul_x) begin
            mul_x_reg <= wdata;
         end
         if (wr_commit && hit_mul_y) begin
            mul_y_reg <= wdata;
         end
         mul_prod_reg <= 16'(mul_x_reg * mul_y_reg);
      end
   end

   // Sticky marker of any access to a reserved location, for debug only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reserved_reg <= 1'b0;
      end else if ((wr_commit || rd_commit) && !any_hit) begin
         reserved_reg <= 1'b1;
      end
   end

   // Outputs straight from flops, hresp tied to OKAY
   assign hreadyout        = hreadyout_reg;
   assign hresp            = 1'b0;
   assign hrdata           = hrdata_reg;
   assign bank_select_flag = flag_reg;
   assign reserved_hit     = reserved_reg;

   // Bank 1 write cannot reach a bank-0-only register
   chk_bank_route: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_commit && ph_bank_reg && !ph_flag_reg
         && (ph_ofs_reg == REG_TABLE[0].offset)
      |=> $stable(store_reg[0]))
      else $error("bank 1 write changed a bank 0 register");

   // Reserved or out-of-map read answers zero
   chk_space_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && !any_hit |=> (hrdata_reg == 32'h00000000))
      else $error("reserved read returned nonzero data");

   // Clearing read empties the decimator high byte
   chk_read_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && hit_dec_h && !dec_in.load
      |=> (dec_high_reg == 8'h00) && (hrdata_reg[7:0] == $past(dec_high_reg)))
      else $error("read-clear did not clear or lost data");

   // Bits outside the write mask of a mixed register hold
   chk_mixed_bits: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_commit && hit[15]
      |=> ((store_reg[15] & ~WM_MX) == ($past(store_reg[15]) & ~WM_MX))
          && ((store_reg[15] & WM_MX) == ($past(hwdata[7:0]) & WM_MX)))
      else $error("mixed register bits not applied per bit");

   // Write-only register reads back zero
   chk_write_only: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && hit[13] |=> (hrdata_reg == 32'h00000000))
      else $error("write-only register read back data");

   // Bank 0 write lands the low data byte in the addressed register
   chk_offset_target: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_commit && hit[0] |=> (store_reg[0] == $past(hwdata[7:0])))
      else $error("write did not reach its offset");

   // Read answer comes after exactly one wait state
   chk_read_wait: assert property (
      @(posedge hclk) disable iff (!hresetn)
      take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");

   // The flag word stores the written bank bit
   chk_flag_write: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_commit && ph_flag_reg
      |=> (flag_reg == $past(hwdata[FLAG_BANK_BIT])))
      else $error("bank-select flag did not take the written bit");

   // Reading the flag word shows the flag in its own bit only
   chk_flag_read: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && ph_flag_reg
      |=> (hrdata_reg == (32'($past(flag_reg)) << FLAG_BANK_BIT)))
      else $error("flag word read back wrong");

   // Bank 1 sees the very flops of the shared analog block
   chk_shared_bank: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && ph_bank_reg && hit[27]
      |=> (hrdata_reg[7:0] == $past(store_reg[27])))
      else $error("shared register differs between banks");

   // A bank-0-only offset reads zero while bank 1 is selected
   chk_bank1_blocked: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && ph_bank_reg && !ph_flag_reg && !ph_rsvd_reg
         && (ph_ofs_reg == REG_TABLE[0].offset)
      |=> (hrdata_reg == 32'h00000000))
      else $error("bank 1 read reached a bank 0 register");

   // A write that hits nothing leaves all storage and the flag alone
   chk_rsvd_write_held: assert property (
      @(posedge hclk) disable iff (!hresetn)
      wr_commit && !any_hit
      |=> $stable(reg_values) && $stable(flag_reg))
      else $error("write to a reserved location changed state");

   // A fresh decimator result is kept even against a clearing read
   chk_dec_load_wins: assert property (
      @(posedge hclk) disable iff (!hresetn)
      dec_in.load
      |=> (dec_high_reg == $past(dec_in.value[15:8]))
          && (dec_low_reg == $past(dec_in.value[7:0])))
      else $error("decimator result lost");

   // Clearing read empties the decimator low byte
   chk_low_clear: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && hit_dec_l && !dec_in.load
      |=> (dec_low_reg == 8'h00) && (hrdata_reg[7:0] == $past(dec_low_reg)))
      else $error("low byte read-clear did not clear or lost data");

   // Multiplier operands are never read back
   chk_mul_write_only: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && (hit_mul_x || hit_mul_y)
      |=> (hrdata_reg == 32'h00000000))
      else $error("multiplier operand read back data");

   // Upper nibble of a mixed register is read-only and never set
   chk_mixed_high_zero: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit && hit[12]
      |=> (hrdata_reg[7:4] == 4'h0))
      else $error("read-only bits of a mixed register were set");

   // Writes finish with no wait state
   chk_write_no_wait: assert property (
      @(posedge hclk) disable iff (!hresetn)
      take && hwrite
      |=> hreadyout)
      else $error("write inserted a wait state");

   // Only the low byte of read data carries a register
   chk_rdata_upper: assert property (
      @(posedge hclk) disable iff (!hresetn)
      rd_commit
      |=> (hrdata_reg[31:8] == 24'h000000))
      else $error("read data upper bytes not zero");

   // Read data stands until the next read completes
   chk_rdata_hold: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !rd_commit
      |=> $stable(hrdata_reg))
      else $error("read data changed outside a read");

endmodule : brm_register_map

// File: tb/brm_register_map_tb_top.sv
// Self-checking bench for the banked register map: AHB-Lite single word
// transfers from tasks, expected values worked out from the register table.
// Assumes hready is looped back from hreadyout (single slave on the bus).
`timescale 1ns/1ps

module brm_register_map_tb_top;
   import brm_pkg::*;

   logic                          hclk;
   logic                          hresetn;
   logic                          hsel;
   logic [31:0]                   haddr;
   logic [1:0]                    htrans;
   logic                          hwrite;
   logic [2:0]                    hsize;
   logic [31:0]                   hwdata;
   logic                          hreadyout;
   logic                          hresp;
   logic [31:0]                   hrdata;
   brm_dec_in_type                dec_in;
   logic [REG_COUNT-1:0][7:0]     reg_values;
   logic                          bank_select_flag;
   logic                          reserved_hit;
   logic [31:0]                   rd;
   int                            error_cnt;
   int                            comparisons;

   brm_register_map i_brm_register_map (
      .hclk             (hclk),
      .hresetn          (hresetn),
      .hsel             (hsel),
      .haddr            (haddr),
      .htrans           (htrans),
      .hwrite           (hwrite),
      .hsize            (hsize),
      .hwdata           (hwdata),
      .hready           (hreadyout),
      .hreadyout        (hreadyout),
      .hresp            (hresp),
      .hrdata           (hrdata),
      .dec_in           (dec_in),
      .reg_values       (reg_values),
      .bank_select_flag (bank_select_flag),
      .reserved_hit     (reserved_hit)
   );

   // Free-running 25 MHz clock
   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // Byte address of a register offset; each byte register takes a word
   function automatic logic [31:0] addr_of(input logic [8:0] idx);
      addr_of = {21'h000000, idx, 2'b00};
   endfunction : addr_of

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // One single transfer; waits on hready, never on a fixed latency
   task automatic ahb_xfer(input logic w, input logic [8:0] idx,
                           input logic [7:0] wd, output logic [31:0] rdat);
      hsel   <= 1'b1;
      haddr  <= addr_of(idx);
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= {24'h000000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdat = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask : ahb_xfer

   task automatic wr(input logic [8:0] idx, input logic [7:0] wd);
      logic [31:0] dummy;
      ahb_xfer(1'b1, idx, wd, dummy);
   endtask : wr

   task automatic rd_chk(input string name, input logic [8:0] idx,
                         input logic [7:0] exp);
      ahb_xfer(1'b0, idx, 8'h00, rd);
      check(name, rd, {24'h000000, exp});
   endtask : rd_chk

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   // Watchdog: the whole sequence needs well under a thousand cycles
   initial begin
      #(40 * 5000);
      error_cnt++;
      tally_and_finish();
   end

   // Main sequence
   initial begin
      error_cnt   = 0;
      comparisons = 0;
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h00000000;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h00000000;
      dec_in  = '{load: 1'b0, value: 16'h0000};
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("reg_values", {31'h0, |reg_values}, 32'h0);
      check("flag", {31'h0, bank_select_flag}, 32'h0);
      check("reserved_hit", {31'h0, reserved_hit}, 32'h0);
      $display("test reset done");

      // Plain storage, back to back write then read
      wr(9'h000, 8'hA5);
      rd_chk("port0_data", 9'h000, 8'hA5);
      check("reg_values0", {24'h0, reg_values[0]}, 32'hA5);
      wr(9'h0E0, 8'h3C);
      rd_chk("interrupt_mask0", 9'h0E0, 8'h3C);
      $display("test storage done");

      // Mixed and write-only registers keep per-bit rights
      wr(9'h020, 8'hFF);
      rd_chk("block0_data0", 9'h020, 8'h0F);
      check("reg_values12", {24'h0, reg_values[12]}, 32'h0F);
      wr(9'h023, 8'hA6);
      rd_chk("block0_control", 9'h023, 8'h06);
      wr(9'h021, 8'h5A);
      rd_chk("block0_data1", 9'h021, 8'h00);
      check("reg_values13", {24'h0, reg_values[13]}, 32'h5A);
      $display("test access rights done");

      // Bank switching: shared block seen in both banks, rest reserved
      wr(9'h080, 8'h66);
      wr(FLAG_INDEX, 8'h01);
      rd_chk("flag_reg", FLAG_INDEX, 8'h01);
      check("flag", {31'h0, bank_select_flag}, 32'h1);
      check("reserved_hit", {31'h0, reserved_hit}, 32'h0);
      rd_chk("sc_block10_b1", 9'h080, 8'h66);
      wr(9'h081, 8'h99);
      wr(9'h000, 8'h77);
      rd_chk("bank1_ofs0", 9'h000, 8'h00);
      check("reserved_hit", {31'h0, reserved_hit}, 32'h1);
      wr(FLAG_INDEX, 8'h00);
      rd_chk("port0_data_b0", 9'h000, 8'hA5);
      rd_chk("sc_block10_ctl1", 9'h081, 8'h99);
      rd_chk("reserved_b0", 9'h00C, 8'h00);
      wr(9'h101, 8'hEE);
      check("reg_values1", {24'h0, reg_values[1]}, 32'h0);
      rd_chk("reserved_idx", 9'h101, 8'h00);
      $display("test banks done");

      // Read-clear decimator bytes
      @(posedge hclk);
      dec_in <= '{load: 1'b1, value: 16'h1234};
      @(posedge hclk);
      dec_in <= '{load: 1'b0, value: 16'h0000};
      @(posedge hclk);
      rd_chk("dec_high", {1'b0, OFS_DEC_HIGH}, 8'h12);
      rd_chk("dec_high_clr", {1'b0, OFS_DEC_HIGH}, 8'h00);
      rd_chk("dec_low", {1'b0, OFS_DEC_LOW}, 8'h34);
      rd_chk("dec_low_clr", {1'b0, OFS_DEC_LOW}, 8'h00);
      $display("test read clear done");

      // Multiplier: write-only operands, read-only product
      wr({1'b0, OFS_MUL_X}, 8'h13);
      wr({1'b0, OFS_MUL_Y}, 8'h21);
      rd_chk("mul_x", {1'b0, OFS_MUL_X}, 8'h00);
      rd_chk("mul_high", {1'b0, OFS_MUL_HIGH}, 8'h02);
      rd_chk("mul_low", {1'b0, OFS_MUL_LOW}, 8'h73);
      $display("test multiplier done");
      tally_and_finish();
   end

endmodule : brm_register_map_tb_top
